// file: hw/ops_pkg.sv
// package for the output pin function select block
package ops_pkg;
	localparam int unsigned NUM_REGS    = 5;
	localparam int unsigned NUM_PINS    = 10;
	localparam int unsigned FIRST_PIN   = 16;
	localparam int unsigned SEL_W       = 5;
	localparam int unsigned REG_W       = 16;
	localparam int unsigned LO_LSB      = 0;
	localparam int unsigned HI_LSB      = 8;
	localparam logic [15:0] REG_RESET   = 16'h0000;
	localparam logic [15:0] REG_MASK    = 16'h1F1F;
	localparam logic [31:0] BASE_ADDR   = 32'h0000_0000;
	localparam logic [31:0] OFF_SEL_16_17 = 32'h0000_0000;
	localparam logic [31:0] OFF_SEL_18_19 = 32'h0000_0004;
	localparam logic [31:0] OFF_SEL_20_21 = 32'h0000_0008;
	localparam logic [31:0] OFF_SEL_22_23 = 32'h0000_000C;
	localparam logic [31:0] OFF_SEL_24_25 = 32'h0000_0010;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
	localparam logic [2:0]  HSIZE_WORD    = 3'h2;

	typedef struct packed {
		logic        sel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
	} ops_ahb_req_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [2:0]  index;
	} ops_acc_t;
endpackage

// file: hw/ops_pin_mux.sv
// one pin's output function multiplexer
`timescale 1ns/1ps
module ops_pin_mux #(
	parameter int unsigned NUM_FUNCS = 32
) (
	input  wire logic [ops_pkg::SEL_W-1:0] selector,
	input  wire logic [NUM_FUNCS-1:0]      periphOut,
	output logic                           pinOut
);
	if (NUM_FUNCS < 1 || NUM_FUNCS > (1 << ops_pkg::SEL_W))
	begin : g_bad_num_funcs
		$error("ops_pin_mux: NUM_FUNCS out of range");
	end

	// function 0 and codes past the table leave the pin at zero
	always_comb
	begin
		pinOut = 1'b0;
		if (selector != '0 && 32'(selector) < NUM_FUNCS)
			pinOut = periphOut[selector];
	end
endmodule

// file: hw/ops_output_select.sv
// output pin function select registers with AHB-Lite slave and pin routing
// Operation
// - register 8 holds pin 17 selector in bits 12-8, pin 16 in 4-0
// - register 9 holds pin 19 selector in bits 12-8, pin 18 in 4-0
// - register 10 holds pin 21 selector in bits 12-8, pin 20 in 4-0
// - register 11 holds pin 23 selector in bits 12-8, pin 22 in 4-0
// - register 12 holds pin 25 selector in bits 12-8, pin 24 in 4-0
// - bits 15-13 and 7-5 of every select register read as zero
// - all selector fields are read/write and clear to zero at reset
`timescale 1ns/1ps
module ops_output_select #(
	parameter int unsigned NUM_FUNCS = 32
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire logic [NUM_FUNCS-1:0]  periphOut,
	output logic      [ops_pkg::NUM_PINS-1:0] remappablePin
);
	// elaboration stops on a function count that the 5-bit selector cannot address
	if (NUM_FUNCS < 1 || NUM_FUNCS > (1 << ops_pkg::SEL_W))
	begin : g_bad_num_funcs
		$error("ops_output_select: NUM_FUNCS out of range");
	end

	logic [ops_pkg::SEL_W-1:0] pinSelector [ops_pkg::NUM_PINS];
	ops_pkg::ops_acc_t         accPhase;
	ops_pkg::ops_ahb_req_t     req;
	logic                      addrHit;
	logic [2:0]                addrIndex;
	logic [ops_pkg::NUM_PINS-1:0] next_pin;
	logic [ops_pkg::NUM_PINS-1:0] pinMuxOut;

	// decode a byte address to a register index; hit flags a mapped word
	function automatic logic [3:0] decodeAddr(input logic [31:0] addr);
		logic [31:0] off;
		off = addr - ops_pkg::BASE_ADDR;
		unique case (off)
			ops_pkg::OFF_SEL_16_17: decodeAddr = {1'b1, 3'h0};
			ops_pkg::OFF_SEL_18_19: decodeAddr = {1'b1, 3'h1};
			ops_pkg::OFF_SEL_20_21: decodeAddr = {1'b1, 3'h2};
			ops_pkg::OFF_SEL_22_23: decodeAddr = {1'b1, 3'h3};
			ops_pkg::OFF_SEL_24_25: decodeAddr = {1'b1, 3'h4};
			default:                decodeAddr = 4'h0;
		endcase
	endfunction

	assign req = '{sel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: hsize, hready: hready};
	assign {addrHit, addrIndex} = decodeAddr(req.haddr);

	// zero wait states, always OKAY; unmapped reads give zero, writes dropped
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// address phase capture
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			accPhase <= '0;
		else if (req.hready)
		begin
			accPhase.valid <= req.sel && req.htrans[1] && addrHit;
			accPhase.write <= req.hwrite;
			accPhase.index <= addrIndex;
		end
	end

	// selector storage, two fields per register
	genvar g;
	generate
		for (g = 0; g < ops_pkg::NUM_PINS; g++)
		begin : g_sel
			localparam int unsigned REGI = g / 2;
			localparam int unsigned LSB  = (g % 2 == 0) ? ops_pkg::LO_LSB : ops_pkg::HI_LSB;
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					pinSelector[g] <= ops_pkg::REG_RESET[LSB +: ops_pkg::SEL_W];
				else if (accPhase.valid && accPhase.write && accPhase.index == 3'(REGI))
					pinSelector[g] <= hwdata[LSB +: ops_pkg::SEL_W];
			end
			ops_pin_mux #(
				.NUM_FUNCS (NUM_FUNCS)
			) u_mux (
				.selector  (pinSelector[g]),
				.periphOut (periphOut),
				.pinOut    (pinMuxOut[g])
			);
		end
	endgenerate

	// read mux: unimplemented bits and upper half stay zero
	always_comb
	begin
		hrdata = 32'h0000_0000;
		if (accPhase.valid && !accPhase.write)
		begin
			for (int i = 0; i < ops_pkg::NUM_REGS; i++)
			begin
				if (accPhase.index == 3'(i))
				begin
					hrdata[ops_pkg::HI_LSB +: ops_pkg::SEL_W] = pinSelector[2*i+1];
					hrdata[ops_pkg::LO_LSB +: ops_pkg::SEL_W] = pinSelector[2*i];
				end
			end
			hrdata[15:0] = hrdata[15:0] & ops_pkg::REG_MASK;
		end
	end

	// registered pins: glitch-free output, one clock after the new selector
	assign next_pin = pinMuxOut;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			remappablePin <= '0;
		else
			remappablePin <= next_pin;
	end

	// assertions
	logic wrPhase;
	assign wrPhase = accPhase.valid && accPhase.write;

	property p_lo_write;
		@(posedge clk) disable iff (!rst_n)
		(wrPhase && accPhase.index == 3'h0) |=> (pinSelector[0] == $past(hwdata[4:0]));
	endproperty
	a_lo_write: assert property (p_lo_write) else $error("pin 16 selector not written");

	property p_hi_write;
		@(posedge clk) disable iff (!rst_n)
		(wrPhase && accPhase.index == 3'h1) |=> (pinSelector[3] == $past(hwdata[12:8]));
	endproperty
	a_hi_write: assert property (p_hi_write) else $error("pin 19 selector not written");

	property p_reg10;
		@(posedge clk) disable iff (!rst_n)
		(wrPhase && accPhase.index == 3'h2) |=> (pinSelector[5] == $past(hwdata[12:8]))
			&& (pinSelector[4] == $past(hwdata[4:0]));
	endproperty
	a_reg10: assert property (p_reg10) else $error("pins 20/21 selector mismatch");

	property p_reg11;
		@(posedge clk) disable iff (!rst_n)
		(wrPhase && accPhase.index == 3'h3) |=> (pinSelector[7] == $past(hwdata[12:8]))
			&& (pinSelector[6] == $past(hwdata[4:0]));
	endproperty
	a_reg11: assert property (p_reg11) else $error("pins 22/23 selector mismatch");

	property p_reg12_hold;
		@(posedge clk) disable iff (!rst_n)
		!(wrPhase && accPhase.index == 3'h4) |=> $stable(pinSelector[9]) && $stable(pinSelector[8]);
	endproperty
	a_reg12_hold: assert property (p_reg12_hold) else $error("pins 24/25 selector changed without write");

	property p_unimpl_zero;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |-> (hrdata[15:13] == 3'h0) && (hrdata[7:5] == 3'h0) && (hrdata[31:16] == 16'h0000);
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits read nonzero");

	property p_readback;
		@(posedge clk) disable iff (!rst_n)
		(accPhase.valid && !accPhase.write && accPhase.index == 3'h0)
			|-> hrdata[12:0] == {pinSelector[1], 3'h0, pinSelector[0]};
	endproperty
	a_readback: assert property (p_readback) else $error("register 8 readback wrong");

	property p_route;
		@(posedge clk) disable iff (!rst_n)
		(pinSelector[0] != 5'h00 && 32'(pinSelector[0]) < NUM_FUNCS)
			|=> remappablePin[0] == $past(periphOut[pinSelector[0]]);
	endproperty
	a_route: assert property (p_route) else $error("pin 16 not routed");

	property p_route_off;
		@(posedge clk) disable iff (!rst_n)
		(pinSelector[9] == 5'h00) [*2] |-> remappablePin[9] == 1'b0;
	endproperty
	a_route_off: assert property (p_route_off) else $error("pin 25 driven while unassigned");

	// per-register field, hold and readback checks
	property p_pin17_write;
		@(posedge clk) disable iff (!rst_n)
		(wrPhase && accPhase.index == 3'h0) |=> (pinSelector[1] == $past(hwdata[12:8]));
	endproperty
	a_pin17_write: assert property (p_pin17_write) else $error("pin 17 selector not written");

	property p_pin18_write;
		@(posedge clk) disable iff (!rst_n)
		(wrPhase && accPhase.index == 3'h1) |=> (pinSelector[2] == $past(hwdata[4:0]));
	endproperty
	a_pin18_write: assert property (p_pin18_write) else $error("pin 18 selector not written");

	property p_reg12;
		@(posedge clk) disable iff (!rst_n)
		(wrPhase && accPhase.index == 3'h4) |=> (pinSelector[9] == $past(hwdata[12:8]))
			&& (pinSelector[8] == $past(hwdata[4:0]));
	endproperty
	a_reg12: assert property (p_reg12) else $error("pins 24/25 selector mismatch");

	property p_reg8_hold;
		@(posedge clk) disable iff (!rst_n)
		!(wrPhase && accPhase.index == 3'h0) |=> $stable(pinSelector[1]) && $stable(pinSelector[0]);
	endproperty
	a_reg8_hold: assert property (p_reg8_hold) else $error("pins 16/17 selector changed without write");

	property p_reg9_hold;
		@(posedge clk) disable iff (!rst_n)
		!(wrPhase && accPhase.index == 3'h1) |=> $stable(pinSelector[3]) && $stable(pinSelector[2]);
	endproperty
	a_reg9_hold: assert property (p_reg9_hold) else $error("pins 18/19 selector changed without write");

	property p_reg10_hold;
		@(posedge clk) disable iff (!rst_n)
		!(wrPhase && accPhase.index == 3'h2) |=> $stable(pinSelector[5]) && $stable(pinSelector[4]);
	endproperty
	a_reg10_hold: assert property (p_reg10_hold) else $error("pins 20/21 selector changed without write");

	property p_reg11_hold;
		@(posedge clk) disable iff (!rst_n)
		!(wrPhase && accPhase.index == 3'h3) |=> $stable(pinSelector[7]) && $stable(pinSelector[6]);
	endproperty
	a_reg11_hold: assert property (p_reg11_hold) else $error("pins 22/23 selector changed without write");

	property p_readback9;
		@(posedge clk) disable iff (!rst_n)
		(accPhase.valid && !accPhase.write && accPhase.index == 3'h1)
			|-> hrdata[12:0] == {pinSelector[3], 3'h0, pinSelector[2]};
	endproperty
	a_readback9: assert property (p_readback9) else $error("register 9 readback wrong");

	property p_readback10;
		@(posedge clk) disable iff (!rst_n)
		(accPhase.valid && !accPhase.write && accPhase.index == 3'h2)
			|-> hrdata[12:0] == {pinSelector[5], 3'h0, pinSelector[4]};
	endproperty
	a_readback10: assert property (p_readback10) else $error("register 10 readback wrong");

	property p_readback11;
		@(posedge clk) disable iff (!rst_n)
		(accPhase.valid && !accPhase.write && accPhase.index == 3'h3)
			|-> hrdata[12:0] == {pinSelector[7], 3'h0, pinSelector[6]};
	endproperty
	a_readback11: assert property (p_readback11) else $error("register 11 readback wrong");

	property p_readback12;
		@(posedge clk) disable iff (!rst_n)
		(accPhase.valid && !accPhase.write && accPhase.index == 3'h4)
			|-> hrdata[12:0] == {pinSelector[9], 3'h0, pinSelector[8]};
	endproperty
	a_readback12: assert property (p_readback12) else $error("register 12 readback wrong");

	property p_idle_read_zero;
		@(posedge clk) disable iff (!rst_n)
		!(accPhase.valid && !accPhase.write) |-> hrdata == 32'h0000_0000;
	endproperty
	a_idle_read_zero: assert property (p_idle_read_zero) else $error("read data outside a read phase");

	// two sampled reset edges, so the first edge of power-up with unknown state is skipped
	property p_reset_clear;
		@(posedge clk)
		(!rst_n) [*2] |-> remappablePin == '0
			&& (pinSelector[0] | pinSelector[1] | pinSelector[2] | pinSelector[3] | pinSelector[4]
			| pinSelector[5] | pinSelector[6] | pinSelector[7] | pinSelector[8] | pinSelector[9]) == 5'h00;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("selectors or pins not cleared in reset");

	property p_unmapped_drop;
		@(posedge clk) disable iff (!rst_n)
		(hsel && htrans[1] && hready && !addrHit) |=> !accPhase.valid;
	endproperty
	a_unmapped_drop: assert property (p_unmapped_drop) else $error("unmapped access accepted");

	property p_route_pin18;
		@(posedge clk) disable iff (!rst_n)
		(pinSelector[2] != 5'h00 && 32'(pinSelector[2]) < NUM_FUNCS)
			|=> remappablePin[2] == $past(periphOut[pinSelector[2]]);
	endproperty
	a_route_pin18: assert property (p_route_pin18) else $error("pin 18 not routed");

	property p_route_pin20;
		@(posedge clk) disable iff (!rst_n)
		(pinSelector[4] != 5'h00 && 32'(pinSelector[4]) < NUM_FUNCS)
			|=> remappablePin[4] == $past(periphOut[pinSelector[4]]);
	endproperty
	a_route_pin20: assert property (p_route_pin20) else $error("pin 20 not routed");

	property p_route_pin25;
		@(posedge clk) disable iff (!rst_n)
		(pinSelector[9] != 5'h00 && 32'(pinSelector[9]) < NUM_FUNCS)
			|=> remappablePin[9] == $past(periphOut[pinSelector[9]]);
	endproperty
	a_route_pin25: assert property (p_route_pin25) else $error("pin 25 not routed");

	property p_route_off16;
		@(posedge clk) disable iff (!rst_n)
		(pinSelector[0] == 5'h00) [*2] |-> remappablePin[0] == 1'b0;
	endproperty
	a_route_off16: assert property (p_route_off16) else $error("pin 16 driven while unassigned");

	c_write: cover property (@(posedge clk) disable iff (!rst_n) wrPhase ##1 wrPhase);
	c_read: cover property (@(posedge clk) disable iff (!rst_n) accPhase.valid && !accPhase.write);
	c_pin: cover property (@(posedge clk) disable iff (!rst_n) $rose(remappablePin[0]));
	c_sel_max: cover property (@(posedge clk) disable iff (!rst_n) pinSelector[9] == 5'h1F);
endmodule

// file: tb/ops_output_select_bench.sv
// self-checking bench for the output pin function select block
`timescale 1ns/1ps
module ops_output_select_bench;
	logic        clk = 1'b0;
	logic        rstN = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = ops_pkg::HSIZE_WORD;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] periphOut = 32'h00000000;
	logic [9:0]  remappablePin;
	logic [15:0] sh [5];
	int          miscompares = 0;
	int          nTests = 0;
	int          cyc = 0;
	localparam logic [31:0] OFFS [5] = '{ops_pkg::OFF_SEL_16_17, ops_pkg::OFF_SEL_18_19,
		ops_pkg::OFF_SEL_20_21, ops_pkg::OFF_SEL_22_23, ops_pkg::OFF_SEL_24_25};

	always #5 clk = ~clk;

	ops_output_select #(.NUM_FUNCS(32)) ops_output_select_i (
		.clk(clk), .rst_n(rstN), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .periphOut(periphOut), .remappablePin(remappablePin));

	task automatic printVerdict;
		$display("counts: tests=%0d mismatches=%0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			printVerdict;
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// entered right after a rising edge; each phase ends at the edge that samples hreadyout high
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= ops_pkg::BASE_ADDR + a;
		htrans <= ops_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= ops_pkg::HSIZE_WORD;
		do
			@(posedge clk);
		while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do
			@(posedge clk);
		while (hreadyout !== 1'b1);
		rd = hrdata;
		check({31'h0, hresp}, 32'h00000000);
	endtask

	function automatic logic [9:0] pinExp(input logic [31:0] p);
		logic [9:0] e;
		for (int k = 0; k < 10; k++)
		begin
			logic [4:0] s;
			s = k[0] ? sh[k/2][12:8] : sh[k/2][4:0];
			e[k] = (s == 5'h00) ? 1'b0 : p[s];
		end
		return e;
	endfunction

	task automatic readAll;
		logic [31:0] rd;
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b0, OFFS[i], 32'h00000000, rd);
			check(rd, {16'h0000, sh[i]});
		end
	endtask

	// pins follow one edge after the selector or peripheral change
	task automatic checkPins;
		@(posedge clk);
		@(negedge clk);
		check({22'h000000, remappablePin}, {22'h000000, pinExp(periphOut)});
		@(posedge clk);
	endtask

	initial
	begin
		logic [31:0] rd;
		logic [31:0] d;
		void'($urandom(32'h353D67EB));
		for (int i = 0; i < 5; i++)
			sh[i] = 16'h0000;
		repeat (5) @(posedge clk);
		rstN <= 1'b1;
		@(posedge clk);
		readAll;
		checkPins;
		$display("test reset values done");
		for (int n = 0; n < 40; n++)
		begin
			for (int i = 0; i < 5; i++)
			begin
				d = (n == 0) ? 32'hFFFFFFFF : (n == 1) ? 32'h00000000 : $urandom;
				bus(1'b1, OFFS[i], d, rd);
				sh[i] = d[15:0] & 16'h1F1F;
			end
			periphOut <= (n == 2) ? 32'hFFFFFFFF : $urandom;
			checkPins;
			bus(1'b1, 32'h00000014 + 32'(n % 4) * 32'h00000010, 32'hFFFFFFFF, rd);
			bus(1'b0, 32'h00000014, 32'h00000000, rd);
			check(rd, 32'h00000000);
			readAll;
		end
		$display("test random selectors done");
		rstN <= 1'b0;
		repeat (2) @(posedge clk);
		rstN <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 5; i++)
			sh[i] = 16'h0000;
		readAll;
		checkPins;
		$display("test second reset done");
		printVerdict;
	end
endmodule
